/* File: cab_result_bank.sv */
// charger result bank behind a two-wire serial slave
`timescale 1ns/1ps

module cab_result_bank
    import cab_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h50
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // two-wire serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // converter results
    input wire logic conv_we,
    input wire logic [2:0] conv_sel,
    input wire logic [7:0] conv_data,
    input wire logic converter_range_select,
    input wire logic five_cell,
    // option fields
    output logic current_monitor_buffer_en,
    output logic low_power_hot_alert_en,
    output logic [1:0] power_monitor_config,
    output logic input_resistor_select,
    output logic charge_resistor_select,
    output logic power_monitor_gain,
    output logic fast_compensation_en,
    output logic comparator_reference_select,
    output logic comparator_polarity,
    output logic [1:0] comparator_deglitch,
    output logic pass_through_en,
    output logic ship_discharge_en,
    output logic auto_wakeup_enable,
    // result scaling
    output logic [15:0] power_step_mv,
    output logic [15:0] comparator_step_mv,
    output logic [15:0] bus_voltage_step_mv,
    output logic [15:0] cell_voltage_step_mv,
    output logic [15:0] cell_voltage_base_mv,
    output logic [15:0] charge_step_ma,
    output logic [15:0] discharge_step_ma,
    output logic [15:0] input_current_step_ma
);

    cab_bank_if bank ();

    cab_result_mem u_mem (
        .clk(clk),
        .resetn(resetn),
        .port(bank.bank)
    );

    cab_state_type state_reg, state_next;
    logic scl_reg;
    logic sda_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic oe_reg;
    logic [15:0] option_reg;
    logic [15:0] power_step_reg;
    logic [15:0] cmp_step_reg;
    logic [15:0] chg_step_reg;
    logic [15:0] dchg_step_reg;
    logic [15:0] iin_step_reg;
    logic [15:0] cell_base_reg;

    // line events
    wire scl_rise = !scl_reg && scl;
    wire scl_fall = scl_reg && !scl;
    wire bus_start = scl_reg && scl && sda_reg && !sda_in;
    wire bus_stop = scl_reg && scl && !sda_reg && sda_in;
    wire byte_done = scl_fall && (cnt_reg == 4'h8);
    wire addr_match = (shift_reg[7:1] == SLAVE_ADDR);

    // register decode
    wire in_results = (ptr_reg >= CAB_OFS_SYS_POWER) && (ptr_reg <= CAB_OFS_SYS_VOLT);
    wire [7:0] ptr_rel = ptr_reg - CAB_OFS_SYS_POWER;
    wire hit_opt_low = (ptr_reg == CAB_OFS_OPTION_LOW);
    wire hit_opt_high = (ptr_reg == CAB_OFS_OPTION_HIGH);
    wire host_write = (state_reg == CAB_WDATA) && byte_done;
    wire host_read_byte = (state_reg == CAB_RDATA) && byte_done;
    wire ptr_advance = host_write || host_read_byte;
    wire [7:0] read_byte;
    assign read_byte = in_results ? bank.rdata :
        hit_opt_low ? option_reg[7:0] :
        hit_opt_high ? option_reg[15:8] :
        CAB_LIMIT_LOW_VALUE;

    // converter side, charge and discharge bytes keep only seven bits
    wire is_dchg = (conv_sel == CAB_IDX_DCHG);
    wire is_chg = (conv_sel == CAB_IDX_CHG);
    wire [7:0] dchg_sat = conv_data[7] ? CAB_CURRENT_MASK : conv_data;
    wire [7:0] cur_byte = is_dchg ? dchg_sat : (conv_data & CAB_CURRENT_MASK);
    assign bank.we = conv_we;
    assign bank.waddr = conv_sel;
    assign bank.wdata = (is_dchg || is_chg) ? cur_byte : conv_data;
    assign bank.raddr = ptr_rel[2:0];

    // open-drain data line, only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda_in;
        end
    end

    // state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CAB_IDLE: begin
                state_next = CAB_IDLE;
            end
            CAB_ADDR: begin
                if (byte_done) begin
                    state_next = addr_match ? CAB_ACK_ADDR : CAB_IDLE;
                end
            end
            CAB_ACK_ADDR: begin
                if (scl_fall) begin
                    state_next = rw_reg ? CAB_RDATA : CAB_PTR;
                end
            end
            CAB_PTR: begin
                if (byte_done) begin
                    state_next = CAB_ACK_PTR;
                end
            end
            CAB_ACK_PTR: begin
                if (scl_fall) begin
                    state_next = CAB_WDATA;
                end
            end
            CAB_WDATA: begin
                if (byte_done) begin
                    state_next = CAB_ACK_WDATA;
                end
            end
            CAB_ACK_WDATA: begin
                if (scl_fall) begin
                    state_next = CAB_WDATA;
                end
            end
            CAB_RDATA: begin
                if (byte_done) begin
                    state_next = CAB_RACK;
                end
            end
            CAB_RACK: begin
                if (scl_fall) begin
                    state_next = shift_reg[0] ? CAB_IDLE : CAB_RDATA;
                end
            end
            default: begin
                state_next = CAB_IDLE;
            end
        endcase
        if (bus_stop) begin
            state_next = CAB_IDLE;
        end
        if (bus_start) begin
            state_next = CAB_ADDR;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= CAB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit count and receive shifter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (bus_start || (scl_fall && state_next != state_reg)) begin
            cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
            shift_reg <= {shift_reg[6:0], sda_in};
        end
    end

    // direction bit from the address byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rw_reg <= 1'b0;
        end else if (state_reg == CAB_ADDR && byte_done) begin
            rw_reg <= shift_reg[0];
        end
    end

    // register pointer, advances after every data byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_reg <= 8'h00;
        end else if (state_reg == CAB_PTR && byte_done) begin
            ptr_reg <= shift_reg;
        end else if (ptr_advance) begin
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // transmit shifter and line drive
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else if (bus_start || bus_stop) begin
            oe_reg <= 1'b0;
        end else if (scl_fall) begin
            unique case (state_next)
                CAB_ACK_ADDR, CAB_ACK_PTR, CAB_ACK_WDATA: begin
                    oe_reg <= 1'b1;
                end
                CAB_RDATA: begin
                    if (state_reg == CAB_RDATA) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        oe_reg <= !tx_reg[6];
                    end else begin
                        tx_reg <= read_byte;
                        oe_reg <= !read_byte[7];
                    end
                end
                default: begin
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // option pair, only writable host target
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            option_reg <= CAB_OPTION_RESET;
        end else if (host_write && hit_opt_low) begin
            option_reg[7:0] <= shift_reg;
        end else if (host_write && hit_opt_high) begin
            option_reg[15:8] <= shift_reg;
        end
    end

    assign current_monitor_buffer_en = option_reg[CAB_BIT_MON_BUF];
    assign low_power_hot_alert_en = option_reg[CAB_BIT_HOT_LPWR];
    assign power_monitor_config = option_reg[CAB_BIT_PMON_CFG +: 2];
    assign input_resistor_select = option_reg[CAB_BIT_IN_RSEL];
    assign charge_resistor_select = option_reg[CAB_BIT_CHG_RSEL];
    assign power_monitor_gain = option_reg[CAB_BIT_PMON_GAIN];
    assign fast_compensation_en = option_reg[CAB_BIT_FAST_COMP];
    assign comparator_reference_select = option_reg[CAB_BIT_COMPARATOR_REFERENCE_SELECT];
    assign comparator_polarity = option_reg[CAB_BIT_COMPARATOR_POLARITY];
    assign comparator_deglitch = option_reg[CAB_BIT_COMPARATOR_DEGLITCH +: 2];
    assign pass_through_en = option_reg[CAB_BIT_PASS_THRU];
    assign ship_discharge_en = option_reg[CAB_BIT_SHIP_DCHG];
    assign auto_wakeup_enable = option_reg[CAB_BIT_AUTO_WAKE];

    // scaling picks, 1 on a resistor bit means 5 mohm
    wire [15:0] range_step = converter_range_select ? CAB_STEP_WIDE_MV : CAB_STEP_NARROW_MV;
    wire in_5m = input_resistor_select;
    wire chg_5m = charge_resistor_select;
    wire [15:0] chg_step_pick = chg_5m ? CAB_STEP_CHG_5M_MA : CAB_STEP_CHG_10M_MA;
    wire [15:0] dchg_step_pick = chg_5m ? CAB_STEP_DCHG_5M_MA : CAB_STEP_DCHG_10M_MA;
    wire [15:0] iin_step_pick = in_5m ? CAB_STEP_IIN_5M_MA : CAB_STEP_IIN_10M_MA;
    wire [15:0] base_pick = five_cell ? CAB_BASE_5CELL_MV : CAB_BASE_4CELL_MV;

    // power and comparator steps follow the full-scale select
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_step_reg <= CAB_STEP_NARROW_MV;
            cmp_step_reg <= CAB_STEP_NARROW_MV;
        end else begin
            power_step_reg <= range_step;
            cmp_step_reg <= range_step;
        end
    end

    // current steps follow the resistor selects
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chg_step_reg <= CAB_STEP_CHG_5M_MA;
            dchg_step_reg <= CAB_STEP_DCHG_5M_MA;
            iin_step_reg <= CAB_STEP_IIN_5M_MA;
        end else begin
            chg_step_reg <= chg_step_pick;
            dchg_step_reg <= dchg_step_pick;
            iin_step_reg <= iin_step_pick;
        end
    end

    // cell voltage base follows the cell count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cell_base_reg <= CAB_BASE_4CELL_MV;
        end else begin
            cell_base_reg <= base_pick;
        end
    end

    assign power_step_mv = power_step_reg;
    assign comparator_step_mv = cmp_step_reg;
    assign bus_voltage_step_mv = CAB_STEP_INPUT_BUS_VOLTAGE_MV;
    assign cell_voltage_step_mv = CAB_STEP_VCELL_MV;
    assign cell_voltage_base_mv = cell_base_reg;
    assign charge_step_ma = chg_step_reg;
    assign discharge_step_ma = dchg_step_reg;
    assign input_current_step_ma = iin_step_reg;

endmodule : cab_result_bank

/* File: cab_pkg.sv */
// constants and types for the charger result bank
package cab_pkg;

    // register offsets
    localparam logic [7:0] CAB_OFS_IIN_LIMIT_LOW = 8'h24;
    localparam logic [7:0] CAB_OFS_SYS_POWER = 8'h26;
    localparam logic [7:0] CAB_OFS_IN_VOLT = 8'h27;
    localparam logic [7:0] CAB_OFS_DCHG_CUR = 8'h28;
    localparam logic [7:0] CAB_OFS_CHG_CUR = 8'h29;
    localparam logic [7:0] CAB_OFS_CMP_IN = 8'h2a;
    localparam logic [7:0] CAB_OFS_IN_CUR = 8'h2b;
    localparam logic [7:0] CAB_OFS_BAT_VOLT = 8'h2c;
    localparam logic [7:0] CAB_OFS_SYS_VOLT = 8'h2d;
    localparam logic [7:0] CAB_OFS_OPTION_LOW = 8'h30;
    localparam logic [7:0] CAB_OFS_OPTION_HIGH = 8'h31;

    // result slots, offset minus the system power offset
    localparam logic [2:0] CAB_IDX_DCHG = 3'h2;
    localparam logic [2:0] CAB_IDX_CHG = 3'h3;
    localparam int CAB_RESULT_DEPTH = 8;

    // option register reset and field positions
    localparam logic [15:0] CAB_OPTION_RESET = 16'h3f00;
    localparam logic [7:0] CAB_LIMIT_LOW_VALUE = 8'h00;
    localparam logic [7:0] CAB_CURRENT_MASK = 8'h7f;
    localparam int CAB_BIT_MON_BUF = 15;
    localparam int CAB_BIT_HOT_LPWR = 14;
    localparam int CAB_BIT_PMON_CFG = 12;
    localparam int CAB_BIT_IN_RSEL = 11;
    localparam int CAB_BIT_CHG_RSEL = 10;
    localparam int CAB_BIT_PMON_GAIN = 9;
    localparam int CAB_BIT_FAST_COMP = 8;
    localparam int CAB_BIT_COMPARATOR_REFERENCE_SELECT = 7;
    localparam int CAB_BIT_COMPARATOR_POLARITY = 6;
    localparam int CAB_BIT_COMPARATOR_DEGLITCH = 4;
    localparam int CAB_BIT_PASS_THRU = 2;
    localparam int CAB_BIT_SHIP_DCHG = 1;
    localparam int CAB_BIT_AUTO_WAKE = 0;

    // result scaling, steps in mV or mA
    localparam logic [15:0] CAB_STEP_WIDE_MV = 16'h000c;
    localparam logic [15:0] CAB_STEP_NARROW_MV = 16'h0008;
    localparam logic [15:0] CAB_STEP_INPUT_BUS_VOLTAGE_MV = 16'h0060;
    localparam logic [15:0] CAB_STEP_VCELL_MV = 16'h0040;
    localparam logic [15:0] CAB_STEP_CHG_10M_MA = 16'h0040;
    localparam logic [15:0] CAB_STEP_CHG_5M_MA = 16'h0080;
    localparam logic [15:0] CAB_STEP_DCHG_10M_MA = 16'h0100;
    localparam logic [15:0] CAB_STEP_DCHG_5M_MA = 16'h0200;
    localparam logic [15:0] CAB_STEP_IIN_10M_MA = 16'h0032;
    localparam logic [15:0] CAB_STEP_IIN_5M_MA = 16'h0064;
    localparam logic [15:0] CAB_BASE_4CELL_MV = 16'h0b40;
    localparam logic [15:0] CAB_BASE_5CELL_MV = 16'h1fe0;

    // serial engine states, gray along the write path
    typedef enum logic [3:0] {
        CAB_IDLE = 4'h0,
        CAB_ADDR = 4'h1,
        CAB_ACK_ADDR = 4'h3,
        CAB_PTR = 4'h2,
        CAB_ACK_PTR = 4'h6,
        CAB_WDATA = 4'h7,
        CAB_ACK_WDATA = 4'h5,
        CAB_RDATA = 4'h4,
        CAB_RACK = 4'hc
    } cab_state_type;

endpackage : cab_pkg

/* File: cab_bank_if.sv */
// result bank write and read port bundle
`timescale 1ns/1ps
interface cab_bank_if;
    logic we;
    logic [2:0] waddr;
    logic [7:0] wdata;
    logic [2:0] raddr;
    logic [7:0] rdata;
    modport bank (input we, input waddr, input wdata, input raddr, output rdata);
    modport user (output we, output waddr, output wdata, output raddr, input rdata);
endinterface : cab_bank_if

/* File: cab_result_mem.sv */
// eight byte result store with registered read
`timescale 1ns/1ps
module cab_result_mem
    import cab_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // access port
    cab_bank_if.bank port
);

    logic [7:0] mem_reg [CAB_RESULT_DEPTH];
    logic [7:0] rdata_reg;

    genvar i;
    generate
        for (i = 0; i < CAB_RESULT_DEPTH; i++) begin : g_entry
            wire hit = port.we && (port.waddr == 3'(i));
            // holds until the converter overwrites it
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_reg[i] <= 8'h00;
                end else if (hit) begin
                    mem_reg[i] <= port.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= mem_reg[port.raddr];
        end
    end

    assign port.rdata = rdata_reg;

endmodule : cab_result_mem

/* File: cab_result_bank_properties.sv */
// port-level properties of the charger result bank
`timescale 1ns/1ps
module cab_result_bank_properties
    import cab_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link
    input wire logic sda_oe,
    // selects
    input wire logic converter_range_select,
    input wire logic five_cell,
    input wire logic current_monitor_buffer_en,
    input wire logic [1:0] power_monitor_config,
    input wire logic input_resistor_select,
    input wire logic charge_resistor_select,
    input wire logic power_monitor_gain,
    input wire logic fast_compensation_en,
    // scaling
    input wire logic [15:0] power_step_mv,
    input wire logic [15:0] comparator_step_mv,
    input wire logic [15:0] bus_voltage_step_mv,
    input wire logic [15:0] cell_voltage_step_mv,
    input wire logic [15:0] cell_voltage_base_mv,
    input wire logic [15:0] charge_step_ma,
    input wire logic [15:0] discharge_step_ma,
    input wire logic [15:0] input_current_step_ma
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a driven low bit is never a one-cycle glitch
    sequence s_oe_hold;
        sda_oe [*2];
    endsequence
    property p_oe_hold;
        $rose(sda_oe) |-> s_oe_hold;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("sda drive shorter than two cycles");
    property p_power_step;
        $past(resetn) && $stable(converter_range_select) |->
            power_step_mv == (converter_range_select ? CAB_STEP_WIDE_MV : CAB_STEP_NARROW_MV);
    endproperty
    a_power_step: assert property (p_power_step) else $error("power step wrong");
    property p_cmp_step;
        $past(resetn) && $stable(converter_range_select) |->
            comparator_step_mv == (converter_range_select ? 16'h000c : 16'h0008);
    endproperty
    a_cmp_step: assert property (p_cmp_step) else $error("comparator step wrong");
    property p_bus_step;
        1'b1 |-> bus_voltage_step_mv == 16'h0060;
    endproperty
    a_bus_step: assert property (p_bus_step) else $error("bus voltage step wrong");
    property p_cell_step;
        1'b1 |-> cell_voltage_step_mv == 16'h0040;
    endproperty
    a_cell_step: assert property (p_cell_step) else $error("cell voltage step wrong");
    property p_cell_base;
        $past(resetn) && $stable(five_cell) |->
            cell_voltage_base_mv == (five_cell ? 16'h1fe0 : 16'h0b40);
    endproperty
    a_cell_base: assert property (p_cell_base) else $error("cell voltage base wrong");
    property p_chg_step;
        $stable(charge_resistor_select) |->
            charge_step_ma == (charge_resistor_select ? 16'h0080 : 16'h0040);
    endproperty
    a_chg_step: assert property (p_chg_step) else $error("charge step wrong");
    property p_dchg_step;
        $stable(charge_resistor_select) |->
            discharge_step_ma == (charge_resistor_select ? 16'h0200 : 16'h0100);
    endproperty
    a_dchg_step: assert property (p_dchg_step) else $error("discharge step wrong");
    property p_iin_step;
        $stable(input_resistor_select) |->
            input_current_step_ma == (input_resistor_select ? 16'h0064 : 16'h0032);
    endproperty
    a_iin_step: assert property (p_iin_step) else $error("input current step wrong");
    property p_opt_reset;
        $rose(resetn) |-> {current_monitor_buffer_en, power_monitor_config, input_resistor_select,
            charge_resistor_select, power_monitor_gain, fast_compensation_en} == 7'h3f;
    endproperty
    a_opt_reset: assert property (p_opt_reset) else $error("option reset value wrong");
endmodule : cab_result_bank_properties

/* File: cab_host_model.sv */
// two-wire host model for the charger result bank link
`timescale 1ns/1ps
module cab_host_model (
    // clock
    input wire logic clk,
    // link
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk
    // phases of four clocks, above the three the slave needs
    task automatic start_cond();
        sda_low <= 1'b0;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_low <= 1'b1;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(4);
    endtask : start_cond
    task automatic stop_cond();
        sda_low <= 1'b1;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_low <= 1'b0;
        wait_clk(4);
    endtask : stop_cond
    // eight data bits then the acknowledge slot
    task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
            output logic ack_rx);
        logic [8:0] word;
        word = {tx, ack_tx};
        for (int i = 8; i >= 0; i--) begin
            sda_low <= !word[i];
            wait_clk(4);
            scl <= 1'b1;
            wait_clk(4);
            word[i] = sda;
            scl <= 1'b0;
            wait_clk(1);
        end
        rx = word[8:1];
        ack_rx = word[0];
    endtask : byte_io
endmodule : cab_host_model

/* File: cab_result_bank_bench.sv */
// self-checking bench for the charger result bank
`timescale 1ns/1ps
module cab_result_bank_bench;
    import cab_pkg::*;
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam int CYCLE_LIMIT = 60000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic conv_we = 1'b0;
    logic [2:0] conv_sel = 3'h0;
    logic [7:0] conv_data = 8'h00;
    logic converter_range_select = 1'b0;
    logic five_cell = 1'b0;
    wire scl, sda_low, sda;
    logic sda_out, sda_oe, current_monitor_buffer_en, low_power_hot_alert_en;
    logic input_resistor_select, charge_resistor_select, power_monitor_gain, fast_compensation_en;
    logic comparator_reference_select, comparator_polarity, pass_through_en, ship_discharge_en;
    logic auto_wakeup_enable;
    logic [1:0] power_monitor_config, comparator_deglitch;
    logic [15:0] power_step_mv, comparator_step_mv, bus_voltage_step_mv, cell_voltage_step_mv;
    logic [15:0] cell_voltage_base_mv, charge_step_ma, discharge_step_ma, input_current_step_ma;
    logic [15:0] opt_seen;
    logic [15:0] pats [3] = '{16'hc0f7, 16'h3a5a, 16'h3f00};
    logic [7:0] raw [8] = '{8'h9c, 8'hff, 8'h85, 8'hc3, 8'h01, 8'hfe, 8'h5a, 8'ha5};
    logic [7:0] kept [8] = '{8'h9c, 8'hff, 8'h7f, 8'h43, 8'h01, 8'hfe, 8'h5a, 8'ha5};
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
    assign opt_seen = {current_monitor_buffer_en, low_power_hot_alert_en, power_monitor_config,
        input_resistor_select, charge_resistor_select, power_monitor_gain, fast_compensation_en,
        comparator_reference_select, comparator_polarity, comparator_deglitch, 1'b0,
        pass_through_en, ship_discharge_en, auto_wakeup_enable};
    always #12.5 clk = ~clk;
    cab_host_model host_i (.clk, .sda, .scl, .sda_low);
    cab_result_bank cab_result_bank_i (.clk, .resetn, .scl, .sda_in(sda), .sda_out, .sda_oe,
        .conv_we, .conv_sel, .conv_data, .converter_range_select, .five_cell,
        .current_monitor_buffer_en, .low_power_hot_alert_en, .power_monitor_config,
        .input_resistor_select, .charge_resistor_select, .power_monitor_gain,
        .fast_compensation_en, .comparator_reference_select, .comparator_polarity,
        .comparator_deglitch, .pass_through_en, .ship_discharge_en, .auto_wakeup_enable,
        .power_step_mv, .comparator_step_mv, .bus_voltage_step_mv, .cell_voltage_step_mv,
        .cell_voltage_base_mv, .charge_step_ma, .discharge_step_ma, .input_current_step_ma);
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] data);
        logic [7:0] rx;
        logic ack;
        host_i.start_cond();
        host_i.byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, ack);
        host_i.byte_io(ofs, 1'b1, rx, ack);
        host_i.byte_io(data, 1'b1, rx, ack);
        check("write ack", {15'h0000, ack}, 16'h0000);
        host_i.stop_cond();
    endtask : wr_reg
    // pointer write, repeated start, one byte closed by a refusal
    task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] data;
        logic ack;
        host_i.start_cond();
        host_i.byte_io({DEV_ADDR, 1'b0}, 1'b1, data, ack);
        host_i.byte_io(ofs, 1'b1, data, ack);
        host_i.start_cond();
        host_i.byte_io({DEV_ADDR, 1'b1}, 1'b1, data, ack);
        host_i.byte_io(8'hff, 1'b1, data, ack);
        host_i.stop_cond();
        check(what, {8'h00, data}, {8'h00, exp});
    endtask : rd_chk
    always @(posedge clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check("option fields", opt_seen, 16'h3f00);
        rd_chk("option low", CAB_OFS_OPTION_LOW, 8'h00);
        rd_chk("option high", CAB_OFS_OPTION_HIGH, 8'h3f);
        $display("test reset done");
        foreach (pats[p]) begin
            wr_reg(CAB_OFS_OPTION_LOW, pats[p][7:0]);
            wr_reg(CAB_OFS_OPTION_HIGH, pats[p][15:8]);
            check("option fields", opt_seen, pats[p] & 16'hfff7);
            rd_chk("option low", CAB_OFS_OPTION_LOW, pats[p][7:0]);
            rd_chk("option high", CAB_OFS_OPTION_HIGH, pats[p][15:8]);
            check("charge step", charge_step_ma, pats[p][10] ? 16'h0080 : 16'h0040);
            check("discharge step", discharge_step_ma, pats[p][10] ? 16'h0200 : 16'h0100);
            check("iin step", input_current_step_ma, pats[p][11] ? 16'h0064 : 16'h0032);
        end
        $display("test option done");
        for (int i = 0; i < 8; i++) begin
            conv_we <= 1'b1;
            conv_sel <= 3'(i);
            conv_data <= raw[i];
            @(posedge clk);
        end
        conv_we <= 1'b0;
        wr_reg(CAB_OFS_SYS_POWER, 8'h11);
        wr_reg(CAB_OFS_IIN_LIMIT_LOW, 8'hff);
        rd_chk("limit low", CAB_OFS_IIN_LIMIT_LOW, 8'h00);
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 8; i++) begin
                rd_chk("result", CAB_OFS_SYS_POWER + 8'(i), kept[i]);
            end
        end
        $display("test results done");
        for (int k = 0; k < 4; k++) begin
            converter_range_select <= k[0];
            five_cell <= k[1];
            repeat (2) @(posedge clk);
            check("power step", power_step_mv, k[0] ? 16'h000c : 16'h0008);
            check("cmp step", comparator_step_mv, k[0] ? 16'h000c : 16'h0008);
            check("bus step", bus_voltage_step_mv, 16'h0060);
            check("cell step", cell_voltage_step_mv, 16'h0040);
            check("cell base", cell_voltage_base_mv, k[1] ? 16'h1fe0 : 16'h0b40);
        end
        $display("test scaling done");
        wr_reg(CAB_OFS_OPTION_HIGH, 8'h00);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk("option high", CAB_OFS_OPTION_HIGH, 8'h3f);
        $display("test second reset done");
        close_out();
    end
endmodule : cab_result_bank_bench
bind cab_result_bank cab_result_bank_properties props_i (.clk, .resetn, .sda_oe,
    .converter_range_select, .five_cell, .current_monitor_buffer_en, .power_monitor_config,
    .input_resistor_select, .charge_resistor_select, .power_monitor_gain, .fast_compensation_en,
    .power_step_mv, .comparator_step_mv, .bus_voltage_step_mv, .cell_voltage_step_mv,
    .cell_voltage_base_mv, .charge_step_ma, .discharge_step_ma, .input_current_step_ma);
